// ==== dv/dcsbm_safety_unit.sv ====
// Behavioural model of the external safety unit with two relay channels
`timescale 1ns/1ps
module dcsbm_safety_unit (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic guard_open, // Guard state set by the bench
  input wire logic hold_a_off, // Channel A fault, held off
  input wire logic feedback, // Monitor feedback from the drive
  output logic safe_input_a_n, // Channel A, low = on
  output logic safe_input_b_n // Channel B, low = on
);
  logic relay_on_q;
  // Relays open with the guard and re-arm only on a good feedback
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      relay_on_q <= 1'b0;
    end else if (guard_open) begin
      relay_on_q <= 1'b0;
    end else if (feedback) begin
      relay_on_q <= 1'b1;
    end
  end
  // Both channels follow the one relay; channel A can also be held off
  assign safe_input_a_n = !relay_on_q || hold_a_off;
  assign safe_input_b_n = !relay_on_q;
endmodule

// ==== dv/testbench.sv ====
// Self-checking testbench for the safe block monitor
`timescale 1ns/1ps
`include "dcsbm_defs.svh"
module testbench;
  import dcsbm_pkg::*;
  localparam int MS = 2000;
  localparam int ALM = 3;
  localparam logic [1:0] OK = `DCSBM_RESP_OK;
  localparam logic [1:0] ER = `DCSBM_RESP_ERR;
  localparam dcsbm_cmd_t SON = 5'h10;
  localparam dcsbm_cmd_t SOTH = 5'h08;
  localparam dcsbm_cmd_t UTIL = 5'h06;
  localparam dcsbm_cmd_t UCAN = 5'h01;
  logic mclk, rst_n, guard_open, hold_a, fb, alarm, irq, a_n, b_n;
  dcsbm_cmd_t cmd, lvl;
  dcsbm_drive_t drive;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int miscompares = 0;
  int n_checks = 0;

  // ----------------------------------------
  // Design, far-side model and clock
  // ----------------------------------------
  dcsbm_top #(.MS_CYCLES(MS), .ALARM_MS(ALM)) DUT (.mclk(mclk), .rst_n(rst_n),
    .safe_input_a_n(a_n), .safe_input_b_n(b_n), .cmd(cmd),
    .brake_off_delay_param(16'h0005), .drive(drive), .monitor_feedback_out(fb),
    .input_timing_alarm(alarm), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  dcsbm_safety_unit unit (.mclk(mclk), .rst_n(rst_n), .guard_open(guard_open),
    .hold_a_off(hold_a), .feedback(fb), .safe_input_a_n(a_n), .safe_input_b_n(b_n));
  // Free-running 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo();
    miscompares++;
    $display("mismatch wait expected done seen timeout");
    conclude();
  endtask
  // Select one observed output by index
  function automatic logic sig(input int s);
    case (s)
      0: return drive.power_en;
      1: return fb;
      default: return alarm;
    endcase
  endfunction
  task automatic wait_v(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && sig(s) !== v; i++) @(posedge mclk);
    if (i == lim) tmo();
  endtask
  task automatic cmdp(input dcsbm_cmd_t c);
    cmd <= c | lvl;
    @(posedge mclk);
    cmd <= lvl;
    repeat (8) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk); // Idle edge between transfers
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 50) tmo();
    chk("bresp", er, bresp);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge mclk); // Idle edge between transfers
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (i == 50) tmo();
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
  endtask

  // ----------------------------------------
  // Scenario sequence
  // ----------------------------------------
  initial begin
    {rst_n, guard_open, hold_a, awvalid, wvalid, bready, arvalid, rready} = '0;
    {cmd, lvl, awaddr, araddr, wdata} = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(8'h00, 32'h0, OK);
    wait_v(1, 1'b1, 20 * MS);
    chk("power", 0, drive.power_en);
    chk("display", 1, drive.block_display);
    wait_v(1, 1'b0, 20 * MS);
    repeat (10) @(posedge mclk);
    rdc(8'h14, 32'h3, OK);
    wr(8'h10, 32'h7, OK);
    wr(8'h00, 32'h1, OK);
    cmdp(SOTH);
    cmdp(SON);
    wait_v(0, 1'b1, 20);
    // Normal servo off keeps the brake released for the set delay
    chk("brake", 1, drive.brake_release_out);
    cmdp(SOTH);
    chk("brake", 1, drive.brake_release_out);
    repeat (6 * MS) @(posedge mclk);
    chk("brake", 0, drive.brake_release_out);
    cmdp(SON);
    wait_v(0, 1'b1, 20);
    wr(8'h0C, 32'h7, OK);
    hold_a <= 1'b1;
    repeat (MS * 2 / 5) @(posedge mclk);
    hold_a <= 1'b0;
    repeat (MS / 2) @(posedge mclk);
    chk("power", 1, drive.power_en);
    guard_open <= 1'b1;
    wait_v(0, 1'b0, 20 * MS);
    // Dynamic brake and block interrupt both settle one edge after block entry
    repeat (2) @(posedge mclk);
    chk("brake", 0, drive.brake_release_out);
    chk("dynbrk", 1, drive.dyn_brake);
    chk("irq", 1, irq);
    wait_v(1, 1'b1, 20 * MS);
    rdc(8'h08, 32'h1, OK);
    wr(8'h0C, 32'h1, OK);
    chk("irq", 0, irq);
    rdc(8'h0C, 32'h0, OK);
    guard_open <= 1'b0;
    wait_v(1, 1'b0, 20 * MS);
    cmdp(SON);
    chk("power", 0, drive.power_en);
    lvl = UTIL;
    cmdp(SOTH);
    cmdp(SON);
    wait_v(0, 1'b1, 20);
    guard_open <= 1'b1;
    wait_v(0, 1'b0, 20 * MS);
    guard_open <= 1'b0;
    wait_v(1, 1'b0, 20 * MS);
    cmdp(SOTH);
    cmdp(SON);
    chk("power", 0, drive.power_en);
    rdc(8'h04, 32'h28, OK);
    lvl = '0;
    cmdp(UCAN);
    lvl = UTIL;
    cmdp(SOTH);
    cmdp(SON);
    wait_v(0, 1'b1, 20);
    wr(8'h0C, 32'h7, OK);
    hold_a <= 1'b1;
    wait_v(0, 1'b0, 20 * MS);
    chk("fb", 0, fb);
    wait_v(2, 1'b1, (ALM + 2) * MS);
    rdc(8'h08, 32'h5, OK);
    wr(8'h10, 32'h0, OK);
    chk("irq", 0, irq);
    hold_a <= 1'b0;
    repeat (10) @(posedge mclk);
    wr(8'h00, 32'h2, OK);
    repeat (3) @(posedge mclk);
    chk("alarm", 0, alarm);
    rdc(8'h40, 32'h0, ER);
    wr(8'h40, 32'h1, ER);
    conclude();
  end
endmodule

// ==== include/dcsbm_defs.svh ====
// Constants for the dual channel safe block monitor
`ifndef DCSBM_DEFS_SVH
`define DCSBM_DEFS_SVH
`define DCSBM_CLK_MHZ 250
`define DCSBM_MS_CYCLES (`DCSBM_CLK_MHZ * 1000)
`define DCSBM_FILT_US 500
`define DCSBM_FILT_TICKS 4
`define DCSBM_ALARM_MS 10000
`define DCSBM_STOP_MAX_MS 20
`define DCSBM_ADDR_CTRL 8'h00
`define DCSBM_ADDR_STAT 8'h04
`define DCSBM_ADDR_IRQ_STAT 8'h08
`define DCSBM_ADDR_IRQ_CLR 8'h0C
`define DCSBM_ADDR_IRQ_EN 8'h10
`define DCSBM_ADDR_MON 8'h14
`define DCSBM_CTRL_RESET 8'h00
`define DCSBM_CTRL_DYN_BIT 0
`define DCSBM_CTRL_ACLR_BIT 1
`define DCSBM_US_PER_MS 1000
`define DCSBM_IRQ_W 3
`define DCSBM_RESP_OK 2'h0
`define DCSBM_RESP_ERR 2'h2
`endif

// ==== include/dcsbm_pkg.sv ====
// Types for the dual channel safe block monitor
package dcsbm_pkg;
  typedef enum logic [1:0] {
    DCSBM_RUN = 2'b00,
    DCSBM_BLOCK = 2'b01,
    DCSBM_BASE = 2'b10
  } dcsbm_state_t;
  typedef struct packed {
    logic power_en;
    logic brake_release_out;
    logic dyn_brake;
    logic block_display;
  } dcsbm_drive_t;
  typedef struct packed {
    logic servo_on;
    logic servo_other;
    logic util_mode;
    logic util_motion;
    logic util_cancel;
  } dcsbm_cmd_t;
endpackage

// ==== rtl/dcsbm_filter.sv ====
// Off-pulse filter for one safety channel
`timescale 1ns/1ps
`include "dcsbm_defs.svh"
module dcsbm_filter #(
  parameter int TICKS = `DCSBM_FILT_TICKS
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic tick, // Filter time base pulse
  input wire logic raw_on, // Raw channel, 1 = on
  output logic filt_on // Filtered channel, 1 = on
);
  logic s1_q, s2_q;
  logic [3:0] cnt_q;
  // Two-flop synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= raw_on;
      s2_q <= s1_q;
    end
  end
  // Off must persist over more than TICKS base ticks; on is taken at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      filt_on <= 1'b0;
    end else if (s2_q) begin
      cnt_q <= 4'h0;
      filt_on <= 1'b1;
    end else if (tick) begin
      if (cnt_q > 4'(TICKS)) begin
        filt_on <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// ==== rtl/dcsbm_top.sv ====
// Dual channel safe block monitor with AXI4-Lite registers
`timescale 1ns/1ps
`include "dcsbm_defs.svh"
module dcsbm_top #(
  parameter int MS_CYCLES = `DCSBM_MS_CYCLES,
  parameter int ALARM_MS = `DCSBM_ALARM_MS,
  parameter int BRK_DLY_W = 16
) (
  input wire logic mclk, // Clock, 250 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic safe_input_a_n, // Safety channel A, low = on
  input wire logic safe_input_b_n, // Safety channel B, low = on
  input wire dcsbm_pkg::dcsbm_cmd_t cmd, // Drive command pulses and levels
  input wire logic [BRK_DLY_W-1:0] brake_off_delay_param, // Brake delay in ms
  output dcsbm_pkg::dcsbm_drive_t drive, // Power stage controls
  output logic monitor_feedback_out, // Feedback to safety unit
  output logic input_timing_alarm, // Timing alarm level
  output logic irq, // Interrupt level
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read valid
  input wire logic s_axi_rready // AXI read ready
);
  import dcsbm_pkg::*;

  // ----------------------------------------------------------------
  // Time base and input filters
  // ----------------------------------------------------------------
  localparam int TICK_CYC = MS_CYCLES * `DCSBM_FILT_US / `DCSBM_US_PER_MS / `DCSBM_FILT_TICKS;
  logic [31:0] pre_q;
  logic tick;
  logic [31:0] ms_q;
  logic ms_tick;
  logic a_on, b_on;

  // Fixed filter tick and millisecond tick
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 32'h0;
      ms_q <= 32'h0;
    end else begin
      pre_q <= (pre_q >= 32'(TICK_CYC - 1)) ? 32'h0 : pre_q + 32'h1;
      ms_q <= (ms_q >= 32'(MS_CYCLES - 1)) ? 32'h0 : ms_q + 32'h1;
    end
  end
  assign tick = (pre_q == 32'(TICK_CYC - 1));
  assign ms_tick = (ms_q == 32'(MS_CYCLES - 1));

  // One filter per channel; an open connector reads as off
  dcsbm_filter u_fa (
    .mclk(mclk), .rst_n(rst_n), .tick(tick),
    .raw_on(~safe_input_a_n), .filt_on(a_on)
  );
  dcsbm_filter u_fb (
    .mclk(mclk), .rst_n(rst_n), .tick(tick),
    .raw_on(~safe_input_b_n), .filt_on(b_on)
  );

  // ----------------------------------------------------------------
  // Block state machine
  // ----------------------------------------------------------------
  dcsbm_state_t st_q;
  logic any_off;
  logic util_lock_q;
  logic [7:0] ctrl_q;
  assign any_off = ~a_on | ~b_on;

  // Block entry has priority over every command, utility mode included
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= DCSBM_BASE;
    end else begin
      case (st_q)
        DCSBM_RUN: begin
          if (any_off) begin
            st_q <= DCSBM_BLOCK;
          end else if (cmd.servo_other) begin
            st_q <= DCSBM_BASE;
          end
        end
        DCSBM_BLOCK: begin
          if (!any_off && cmd.servo_other) begin
            st_q <= DCSBM_BASE;
          end
        end
        DCSBM_BASE: begin
          if (any_off) begin
            st_q <= DCSBM_BLOCK;
          end else if (cmd.servo_on && !util_lock_q) begin
            st_q <= DCSBM_RUN;
          end
        end
        default: st_q <= DCSBM_BLOCK;
      endcase
    end
  end

  // Motion utility interrupted by block stays locked until cancelled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      util_lock_q <= 1'b0;
    end else if (cmd.util_motion && any_off) begin
      util_lock_q <= 1'b1;
    end else if (cmd.util_cancel) begin
      util_lock_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the power stage
  // ----------------------------------------------------------------
  logic blk;
  logic [BRK_DLY_W-1:0] brk_cnt_q;
  logic brk_q;
  assign blk = (st_q == DCSBM_BLOCK);

  // Brake release: delayed on normal stop, immediate on block
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      brk_q <= 1'b0;
      brk_cnt_q <= '0;
    end else if (blk || any_off) begin
      brk_q <= 1'b0;
      brk_cnt_q <= '0;
    end else if (st_q == DCSBM_RUN) begin
      brk_q <= 1'b1;
      brk_cnt_q <= brake_off_delay_param;
    end else if (brk_cnt_q != '0) begin
      if (ms_tick) begin
        brk_cnt_q <= brk_cnt_q - BRK_DLY_W'(1);
      end
    end else begin
      brk_q <= 1'b0;
    end
  end

  // Drive struct and feedback registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive <= '0;
      monitor_feedback_out <= 1'b0;
    end else begin
      drive.power_en <= (st_q == DCSBM_RUN) && !any_off;
      drive.brake_release_out <= brk_q && !any_off;
      drive.dyn_brake <= blk && ctrl_q[`DCSBM_CTRL_DYN_BIT];
      drive.block_display <= blk || any_off;
      monitor_feedback_out <= ~a_on & ~b_on;
    end
  end

  // ----------------------------------------------------------------
  // Input timing alarm
  // ----------------------------------------------------------------
  logic [31:0] mis_q;
  logic mismatch;
  assign mismatch = a_on ^ b_on;

  // Count milliseconds of one-sided off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mis_q <= 32'h0;
      input_timing_alarm <= 1'b0;
    end else begin
      if (!mismatch) begin
        mis_q <= 32'h0;
      end else if (ms_tick && mis_q < 32'(ALARM_MS)) begin
        mis_q <= mis_q + 32'h1;
      end
      if (mismatch && mis_q >= 32'(ALARM_MS)) begin
        input_timing_alarm <= 1'b1;
      end else if (ctrl_q[`DCSBM_CTRL_ACLR_BIT]) begin
        input_timing_alarm <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and registers
  // ----------------------------------------------------------------
  logic [`DCSBM_IRQ_W-1:0] ist_q, ien_q, ev, clr;
  logic blk_d1_q, alm_d1_q;
  logic wr_go;
  assign ev = {input_timing_alarm & ~alm_d1_q, ~blk & blk_d1_q, blk & ~blk_d1_q};
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign clr = (wr_go && s_axi_awaddr == `DCSBM_ADDR_IRQ_CLR) ?
               s_axi_wdata[`DCSBM_IRQ_W-1:0] : '0;
  assign irq = |(ist_q & ien_q);

  // Sticky status; a new event wins over a clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ist_q <= '0;
      blk_d1_q <= 1'b0;
      alm_d1_q <= 1'b0;
    end else begin
      blk_d1_q <= blk;
      alm_d1_q <= input_timing_alarm;
      ist_q <= (ist_q & ~clr) | ev;
    end
  end

  // AXI write channel, address and data taken together
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCSBM_RESP_OK;
      ctrl_q <= `DCSBM_CTRL_RESET;
      ien_q <= '0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DCSBM_RESP_OK;
        case (s_axi_awaddr)
          `DCSBM_ADDR_CTRL: if (s_axi_wstrb[0]) ctrl_q <= s_axi_wdata[7:0];
          `DCSBM_ADDR_IRQ_EN: if (s_axi_wstrb[0]) ien_q <= s_axi_wdata[`DCSBM_IRQ_W-1:0];
          `DCSBM_ADDR_IRQ_CLR: ;
          default: s_axi_bresp <= `DCSBM_RESP_ERR;
        endcase
      end
    end
  end

  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DCSBM_RESP_OK;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DCSBM_RESP_OK;
      case (s_axi_araddr)
        `DCSBM_ADDR_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
        `DCSBM_ADDR_STAT: s_axi_rdata <= {26'h0, util_lock_q, input_timing_alarm,
                                           st_q, monitor_feedback_out, blk};
        `DCSBM_ADDR_IRQ_STAT: s_axi_rdata <= {29'h0, ist_q};
        `DCSBM_ADDR_IRQ_CLR: s_axi_rdata <= 32'h0;
        `DCSBM_ADDR_IRQ_EN: s_axi_rdata <= {29'h0, ien_q};
        `DCSBM_ADDR_MON: s_axi_rdata <= {30'h0, b_on, a_on};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `DCSBM_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_fb_both_off;
    @(posedge mclk) disable iff (!rst_n) 1'b1 |=> (monitor_feedback_out == $past(~a_on & ~b_on));
  endproperty
  a_fb_both_off: assert property (p_fb_both_off) else $error("feedback mismatch");
  property p_power_cut;
    @(posedge mclk) disable iff (!rst_n) any_off |=> !drive.power_en;
  endproperty
  a_power_cut: assert property (p_power_cut) else $error("power not cut");
  property p_block_enter;
    @(posedge mclk) disable iff (!rst_n) (any_off && st_q == DCSBM_RUN) |=> blk;
  endproperty
  a_block_enter: assert property (p_block_enter) else $error("block not entered");
  property p_brake_off;
    @(posedge mclk) disable iff (!rst_n) blk |=> !drive.brake_release_out;
  endproperty
  a_brake_off: assert property (p_brake_off) else $error("brake release on in block");
  property p_brake_nodly;
    @(posedge mclk) disable iff (!rst_n) $rose(any_off) |=> !brk_q;
  endproperty
  a_brake_nodly: assert property (p_brake_nodly) else $error("brake delayed");
  property p_dyn;
    @(posedge mclk) disable iff (!rst_n) (blk && ctrl_q[`DCSBM_CTRL_DYN_BIT]) |=> drive.dyn_brake;
  endproperty
  a_dyn: assert property (p_dyn) else $error("dynamic brake missing");
  property p_lock;
    @(posedge mclk) disable iff (!rst_n) (util_lock_q && st_q == DCSBM_BASE) |=> st_q != DCSBM_RUN;
  endproperty
  a_lock: assert property (p_lock) else $error("locked utility resumed");
  property p_disp;
    @(posedge mclk) disable iff (!rst_n) any_off |=> drive.block_display;
  endproperty
  a_disp: assert property (p_disp) else $error("display missing");
  property p_alarm_quiet;
    @(posedge mclk) disable iff (!rst_n) (!mismatch && !input_timing_alarm) |=> !input_timing_alarm;
  endproperty
  a_alarm_quiet: assert property (p_alarm_quiet) else $error("spurious alarm");
  c_block: cover property (@(posedge mclk) disable iff (!rst_n) $rose(blk));
  c_run: cover property (@(posedge mclk) disable iff (!rst_n) $rose(st_q == DCSBM_RUN));
  c_fb: cover property (@(posedge mclk) disable iff (!rst_n) $rose(monitor_feedback_out));
  c_util_block: cover property (@(posedge mclk) disable iff (!rst_n) cmd.util_mode && $rose(blk));
endmodule
